/* File: pkg/smos_pkg.sv */
// package: constants, codes and helpers of the two-channel monitor output block
package smos_pkg;
  localparam int CLK_NS = 25;
  localparam int TICK_US = 250;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int SEC_CYC = 1000000000 / CLK_NS;
  localparam int WINDOW_MIN = 30;
  localparam int WINDOW_SEC = WINDOW_MIN * 60;
  localparam logic [31:0] WS_PER_WH = 32'h00000E10;
  localparam int SCALE_BITS = 42;
  localparam logic [9:0] MV_PER_V = 10'h3E8;
  localparam logic signed [15:0] MV_FULL = 16'sh2710;
  localparam logic signed [15:0] MV_HALF = 16'sh1388;
  localparam logic signed [15:0] MV_SAT = 16'sh4E20;
  localparam logic [7:0] A_TYPE1 = 8'h00;
  localparam logic [7:0] A_GAIN1 = 8'h04;
  localparam logic [7:0] A_TYPE2 = 8'h08;
  localparam logic [7:0] A_GAIN2 = 8'h0C;
  localparam logic [7:0] A_FMT = 8'h10;
  localparam logic [7:0] A_EXT2 = 8'h14;
  localparam logic [7:0] A_POL = 8'h18;
  localparam logic [7:0] A_OUT = 8'h1C;
  localparam logic [7:0] A_ENERGY = 8'h20;
  localparam int DEV_SEL_BIT = 14;
  localparam logic [7:0] POL_REVERSE = 8'hE0;
  localparam logic [4:0] RST_TYPE = 5'h00;
  localparam logic [31:0] RST_GAIN = 32'h00000000;
  localparam logic [1:0] RST_FMT = 2'h0;
  localparam logic [15:0] RST_EXT2 = 16'h0000;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [1:0] FMT_SIGNED = 2'h0;
  localparam logic [1:0] FMT_ABS = 2'h1;
  localparam logic [1:0] FMT_OFFSET = 2'h2;
  localparam logic [4:0] T_VEL = 5'h00;
  localparam logic [4:0] T_CMD_PRE = 5'h01;
  localparam logic [4:0] T_CMD_POST = 5'h02;
  localparam logic [4:0] T_VLOOP = 5'h03;
  localparam logic [4:0] T_TRQ = 5'h04;
  localparam logic [4:0] T_CMD_DEV = 5'h05;
  localparam logic [4:0] T_ENC_DEV = 5'h06;
  localparam logic [4:0] T_EXT_DEV = 5'h07;
  localparam logic [4:0] T_HYB_DEV = 5'h08;
  localparam logic [4:0] T_PN = 5'h09;
  localparam logic [4:0] T_REGEN = 5'h0A;
  localparam logic [4:0] T_OVL = 5'h0B;
  localparam logic [4:0] T_TLIM_P = 5'h0C;
  localparam logic [4:0] T_TLIM_N = 5'h0D;
  localparam logic [4:0] T_SPD_LIM = 5'h0E;
  localparam logic [4:0] T_INERTIA = 5'h0F;
  localparam logic [4:0] T_ENC_TEMP = 5'h13;
  localparam logic [4:0] T_DRV_TEMP = 5'h14;
  localparam logic [4:0] T_SINGLE = 5'h15;
  localparam logic [4:0] T_TRAVEL = 5'h17;
  localparam logic [4:0] T_GAIN_SEL = 5'h18;
  localparam logic [4:0] T_POS_DONE = 5'h19;
  localparam logic [4:0] T_ALARM = 5'h1A;
  localparam logic [4:0] T_POWER = 5'h1B;
  localparam logic [4:0] T_ENERGY = 5'h1C;
  localparam logic [31:0] G_VEL = 32'h000001F4;
  localparam logic [31:0] G_PCT = 32'h00000021;
  localparam logic [31:0] G_DEV = 32'h00000BB8;
  localparam logic [31:0] G_PN = 32'h00000050;
  localparam logic [31:0] G_INERTIA = 32'h000001F4;
  localparam logic [31:0] G_TEMP = 32'h0000000A;
  localparam logic [31:0] G_SINGLE = 32'h0001ADB0;
  localparam logic [31:0] G_POWER = 32'h00000064;
  localparam logic [31:0] G_UNITY = 32'h00000001;

  typedef enum logic [1:0] {MODE_PP, MODE_CSP, MODE_VEL, MODE_TRQ} smos_mode_e;

  // unused codes get unity so the divider never sees zero
  function automatic logic [31:0] smos_default_gain(input logic [4:0] t);
    if (t <= T_VLOOP || t == T_SPD_LIM) return G_VEL;
    if (t == T_TRQ || (t >= T_REGEN && t <= T_TLIM_N)) return G_PCT;
    if (t >= T_CMD_DEV && t <= T_HYB_DEV) return G_DEV;
    if (t == T_PN) return G_PN;
    if (t == T_INERTIA) return G_INERTIA;
    if (t == T_ENC_TEMP || t == T_DRV_TEMP) return G_TEMP;
    if (t == T_SINGLE) return G_SINGLE;
    if (t == T_POWER || t == T_ENERGY) return G_POWER;
    return G_UNITY;
  endfunction
endpackage

/* File: rtl/smos_scale.sv */
// module: signed value to millivolts, value * 1000 / gain, by a serial divider
module smos_scale
  import smos_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [31:0] value,
  input wire logic [31:0] gain,
  output logic signed [15:0] result,
  output logic done
);
  typedef enum logic [1:0] {SC_LOAD, SC_RUN, SC_DONE} smos_sc_e;
  smos_sc_e st_q;
  logic [41:0] quo_q;
  logic [32:0] rem_q;
  logic [31:0] den_q;
  logic [5:0] cnt_q;
  logic neg_q;
  logic done_q;
  logic signed [15:0] result_q;
  logic [31:0] mag;
  logic [32:0] trial;
  logic ge;
  logic [15:0] sat;

  always_comb begin
    mag = value[31] ? 32'(-value) : 32'(value);
    trial = {rem_q[31:0], quo_q[41]};
    ge = trial >= {1'b0, den_q};
    sat = (quo_q > 42'(MV_SAT)) ? MV_SAT : quo_q[15:0];
  end

  // free-running: load, 42 divide steps, publish, reload
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= SC_LOAD;
      quo_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      neg_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= '0;
    end else if (ce) begin
      done_q <= 1'b0;
      unique case (st_q)
        SC_LOAD: begin
          neg_q <= value[31];
          quo_q <= 42'(mag) * 42'(MV_PER_V);
          rem_q <= '0;
          den_q <= gain;
          cnt_q <= 6'(SCALE_BITS);
          st_q <= SC_RUN;
        end
        SC_RUN: begin
          rem_q <= ge ? trial - {1'b0, den_q} : trial;
          quo_q <= {quo_q[40:0], ge};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) st_q <= SC_DONE;
        end
        SC_DONE: begin
          result_q <= neg_q ? -signed'(sat) : signed'(sat);
          done_q <= 1'b1;
          st_q <= SC_LOAD;
        end
      endcase
    end
  end

  assign result = result_q;
  assign done = done_q;

  sat_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    done_q |-> (result_q <= MV_SAT && result_q >= -MV_SAT)) else $error("scaled result beyond saturation");
endmodule

/* File: rtl/smos_energy.sv */
// module: energy consumed per half-hour window in Wh, published at window end
module smos_energy
  import smos_pkg::*;
#(
  parameter int SEC_CYC_P = SEC_CYC,
  parameter int WINDOW_SEC_P = WINDOW_SEC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [31:0] power_w,
  output logic [31:0] energy_wh
);
  logic [31:0] sec_cnt_q;
  logic sec_q;
  logic [31:0] win_cnt_q;
  logic [31:0] ws_q;
  logic [31:0] wh_q;
  logic [31:0] energy_q;
  logic [31:0] add;
  logic win_end;

  always_comb begin
    add = (sec_q && !power_w[31]) ? 32'(power_w) : 32'h00000000;
    win_end = sec_q && win_cnt_q == 32'(WINDOW_SEC_P - 1);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sec_cnt_q <= '0;
      sec_q <= 1'b0;
    end else if (ce) begin
      sec_q <= sec_cnt_q == 32'(SEC_CYC_P - 1);
      sec_cnt_q <= (sec_cnt_q == 32'(SEC_CYC_P - 1)) ? 32'h00000000 : sec_cnt_q + 32'h00000001;
    end
  end

  // one watt-second per second of power; whole Wh drained between seconds
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      win_cnt_q <= '0;
      ws_q <= '0;
      wh_q <= '0;
      energy_q <= '0;
    end else if (ce) begin
      if (win_end) begin
        energy_q <= wh_q;
        wh_q <= '0;
        ws_q <= add;
        win_cnt_q <= '0;
      end else begin
        if (sec_q) win_cnt_q <= win_cnt_q + 32'h00000001;
        if (ws_q >= WS_PER_WH) begin
          ws_q <= ws_q - WS_PER_WH + add;
          wh_q <= wh_q + 32'h00000001;
        end else begin
          ws_q <= ws_q + add;
        end
      end
    end
  end

  assign energy_wh = energy_q;

  energy_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !(ce && win_end) |=> $stable(energy_q)) else $error("energy value changed inside a window");
endmodule

/* File: rtl/smos_top.sv */
// top: AHB-Lite register slave and two scaled monitor output channels
// Summary of operation
// - a zero gain setting selects the selected type's default gain
// - velocity types are in r/min with default gain 500
// - percentage types default to 33 percent per volt
// - the four deviation types count pulses, default gain 3000
// - motor power in W and energy in Wh both default to 100
// - energy shows the half-hour total, updated once per half hour
// - signs follow the polarity setting only for the velocity, torque, deviation and speed-limit types
// - encoder single-turn data is CCW positive, default gain 110000
// - command speed is taken before filters, internal speed after them
// - deviation select bit 0 uses post-filter command, 1 pre-filter
// - binary status types ignore gain and drive one of two levels
// - travel status: 0 V if command nonzero, 5 V if zero, 250us sampling in MODE_PP, every clock in velocity and torque modes
// - synchronous position mode samples travel once per communication cycle
// - gain status: 0 V for second or third set, 5 V for first
// - positioning-complete and alarm: 0 V for flag 0, 5 V for flag 1
// - format picks signed 10 V, absolute 10 V, or 5 V centred
// - gain is the monitored value that maps to exactly 1 V
// - each channel selects its own type code 0 to 28
module smos_top
  import smos_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC,
  parameter int SEC_CYC_P = SEC_CYC,
  parameter int WINDOW_SEC_P = WINDOW_SEC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic signed [31:0] motor_vel,
  input wire logic signed [31:0] cmd_vel_pre,
  input wire logic signed [31:0] cmd_vel_post,
  input wire logic signed [31:0] vel_loop_cmd,
  input wire logic signed [31:0] torque_cmd,
  input wire logic signed [31:0] pos_dev_post,
  input wire logic signed [31:0] pos_dev_pre,
  input wire logic signed [31:0] enc_dev,
  input wire logic signed [31:0] ext_dev,
  input wire logic signed [31:0] hyb_dev,
  input wire logic signed [31:0] pn_volt,
  input wire logic signed [31:0] regen_load,
  input wire logic signed [31:0] overload_load,
  input wire logic signed [31:0] tlim_pos,
  input wire logic signed [31:0] tlim_neg,
  input wire logic signed [31:0] speed_limit,
  input wire logic signed [31:0] inertia_ratio,
  input wire logic signed [31:0] enc_temp,
  input wire logic signed [31:0] drv_temp,
  input wire logic signed [31:0] enc_single_turn,
  input wire logic signed [31:0] power_w,
  input wire logic signed [31:0] travel_cmd,
  input wire logic signed [31:0] vel_cmd,
  input wire logic [1:0] ctrl_mode,
  input wire logic comm_cycle_tick,
  input wire logic [1:0] gain_set,
  input wire logic pos_complete,
  input wire logic alarm_active,
  output logic signed [15:0] mon1_mv,
  output logic signed [15:0] mon2_mv
);
  logic [4:0] type_q [2];
  logic [31:0] gain_q [2];
  logic [1:0] fmt_q;
  logic [15:0] ext2_q;
  logic [7:0] pol_q;
  logic wr_pend_q;
  logic [31:0] waddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] rd_d;
  logic [31:0] energy_wh;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic travel_zero_q;
  logic signed [15:0] out_q [2];
  logic signed [31:0] sel_v [2];
  logic signed [31:0] pol_v [2];
  logic [31:0] eff_gain [2];
  logic signed [15:0] res [2];
  logic done [2];
  logic lvl [2];

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    return a[31:8] == 24'h000000 && a[7:0] == off;
  endfunction

  function automatic logic is_digital(input logic [4:0] t);
    return t >= T_TRAVEL && t <= T_ALARM;
  endfunction

  // single-turn data is left out here: it is always CCW positive
  function automatic logic pol_applies(input logic [4:0] t);
    return t <= T_HYB_DEV || t == T_SPD_LIM;
  endfunction

  function automatic logic signed [15:0] fmt_out(input logic signed [15:0] v, input logic [1:0] f);
    logic signed [16:0] w;
    logic signed [16:0] hi;
    logic signed [16:0] lo;
    hi = 17'(MV_FULL);
    lo = (f == FMT_ABS || f == FMT_OFFSET) ? 17'sh00000 : -hi;
    w = 17'(v);
    if (f == FMT_ABS && w < 0) w = -w;
    if (f == FMT_OFFSET) w = w + 17'(MV_HALF);
    if (w > hi) w = hi;
    else if (w < lo) w = lo;
    return w[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, reads captured in the address phase

  always_comb begin
    rd_d = '0;
    if (hit(haddr, A_TYPE1)) rd_d[4:0] = type_q[0];
    else if (hit(haddr, A_GAIN1)) rd_d = gain_q[0];
    else if (hit(haddr, A_TYPE2)) rd_d[4:0] = type_q[1];
    else if (hit(haddr, A_GAIN2)) rd_d = gain_q[1];
    else if (hit(haddr, A_FMT)) rd_d[1:0] = fmt_q;
    else if (hit(haddr, A_EXT2)) rd_d[15:0] = ext2_q;
    else if (hit(haddr, A_POL)) rd_d[7:0] = pol_q;
    else if (hit(haddr, A_OUT)) rd_d = {out_q[1], out_q[0]};
    else if (hit(haddr, A_ENERGY)) rd_d = energy_wh;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      waddr_q <= '0;
      hrdata_q <= '0;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      waddr_q <= haddr;
      if (hsel && htrans[1] && !hwrite) hrdata_q <= rd_d;
    end
  end

  // never stalls and never errors, so both stay at their idle answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        type_q[i] <= RST_TYPE;
        gain_q[i] <= RST_GAIN;
      end
      fmt_q <= RST_FMT;
      ext2_q <= RST_EXT2;
      pol_q <= RST_POL;
    end else if (wr_pend_q) begin
      if (hit(waddr_q, A_TYPE1)) type_q[0] <= hwdata[4:0];
      else if (hit(waddr_q, A_GAIN1)) gain_q[0] <= hwdata;
      else if (hit(waddr_q, A_TYPE2)) type_q[1] <= hwdata[4:0];
      else if (hit(waddr_q, A_GAIN2)) gain_q[1] <= hwdata;
      else if (hit(waddr_q, A_FMT)) fmt_q <= hwdata[1:0];
      else if (hit(waddr_q, A_EXT2)) ext2_q <= hwdata[15:0];
      else if (hit(waddr_q, A_POL)) pol_q <= hwdata[7:0];
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // travel-command status sampling

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= tick_cnt_q == 32'(TICK_CYC_P - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC_P - 1)) ? 32'h00000000 : tick_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      travel_zero_q <= 1'b1;
    end else if (ce) begin
      unique case (smos_mode_e'(ctrl_mode))
        MODE_PP: if (tick_q) travel_zero_q <= travel_cmd == 0;
        MODE_CSP: if (comm_cycle_tick) travel_zero_q <= travel_cmd == 0;
        MODE_VEL: travel_zero_q <= vel_cmd == 0;
        MODE_TRQ: travel_zero_q <= torque_cmd == 0;
      endcase
    end
  end

  smos_energy #(
    .SEC_CYC_P(SEC_CYC_P),
    .WINDOW_SEC_P(WINDOW_SEC_P)
  ) u_energy (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .power_w(power_w),
    .energy_wh(energy_wh)
  );

  ////////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_comb begin
      case (type_q[c])
        T_VEL: sel_v[c] = motor_vel;
        T_CMD_PRE: sel_v[c] = cmd_vel_pre;
        T_CMD_POST: sel_v[c] = cmd_vel_post;
        T_VLOOP: sel_v[c] = vel_loop_cmd;
        T_TRQ: sel_v[c] = torque_cmd;
        T_CMD_DEV: sel_v[c] = ext2_q[DEV_SEL_BIT] ? pos_dev_pre : pos_dev_post;
        T_ENC_DEV: sel_v[c] = enc_dev;
        T_EXT_DEV: sel_v[c] = ext_dev;
        T_HYB_DEV: sel_v[c] = hyb_dev;
        T_PN: sel_v[c] = pn_volt;
        T_REGEN: sel_v[c] = regen_load;
        T_OVL: sel_v[c] = overload_load;
        T_TLIM_P: sel_v[c] = tlim_pos;
        T_TLIM_N: sel_v[c] = tlim_neg;
        T_SPD_LIM: sel_v[c] = speed_limit;
        T_INERTIA: sel_v[c] = inertia_ratio;
        T_ENC_TEMP: sel_v[c] = enc_temp;
        T_DRV_TEMP: sel_v[c] = drv_temp;
        T_SINGLE: sel_v[c] = enc_single_turn;
        T_POWER: sel_v[c] = power_w;
        T_ENERGY: sel_v[c] = signed'(energy_wh);
        default: sel_v[c] = '0;
      endcase
      pol_v[c] = (pol_q == POL_REVERSE && pol_applies(type_q[c])) ? -sel_v[c] : sel_v[c];
      eff_gain[c] = (gain_q[c] == 32'h00000000) ? smos_default_gain(type_q[c]) : gain_q[c];
      case (type_q[c])
        T_TRAVEL: lvl[c] = travel_zero_q;
        T_GAIN_SEL: lvl[c] = gain_set == 2'h0;
        T_POS_DONE: lvl[c] = pos_complete;
        T_ALARM: lvl[c] = alarm_active;
        default: lvl[c] = 1'b0;
      endcase
    end

    smos_scale u_scale (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .value(pol_v[c]),
      .gain(eff_gain[c]),
      .result(res[c]),
      .done(done[c])
    );

    // status types bypass the gain and the format entirely
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        out_q[c] <= '0;
      end else if (ce) begin
        if (is_digital(type_q[c])) out_q[c] <= lvl[c] ? MV_HALF : 16'sh0000;
        else if (done[c]) out_q[c] <= fmt_out(res[c], fmt_q);
      end
    end
  end

  assign mon1_mv = out_q[0];
  assign mon2_mv = out_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  out_range_a: assert property (out_q[0] <= MV_FULL && out_q[0] >= -MV_FULL)
    else $error("channel 1 output beyond 10 V");
  abs_sign_a: assert property ((ce && done[1] && fmt_q == FMT_ABS && !is_digital(type_q[1]))
    |=> out_q[1] >= 0) else $error("absolute format gave a negative level");
  vel_gain_a: assert property ((type_q[0] == T_VEL && gain_q[0] == 32'h00000000)
    |-> eff_gain[0] == G_VEL) else $error("velocity default gain wrong");
  pct_gain_a: assert property ((type_q[0] == T_TRQ && gain_q[0] == 32'h00000000)
    |-> eff_gain[0] == G_PCT) else $error("torque default gain wrong");
  dev_gain_a: assert property ((type_q[1] == T_ENC_DEV && gain_q[1] == 32'h00000000)
    |-> eff_gain[1] == G_DEV) else $error("deviation default gain wrong");
  turn_sign_a: assert property ((type_q[0] == T_SINGLE) |-> pol_v[0] == enc_single_turn)
    else $error("single-turn data followed polarity");
  pol_flip_a: assert property ((type_q[0] == T_VEL && pol_q == POL_REVERSE)
    |-> pol_v[0] == -motor_vel) else $error("polarity not applied to velocity");
  dev_sel_a: assert property ((type_q[0] == T_CMD_DEV)
    |-> sel_v[0] == (ext2_q[DEV_SEL_BIT] ? pos_dev_pre : pos_dev_post)) else $error("deviation source wrong");
  alarm_lvl_a: assert property ((ce && type_q[0] == T_ALARM)
    |=> out_q[0] == ($past(alarm_active) ? MV_HALF : 16'sh0000)) else $error("alarm level wrong");
  gain_lvl_a: assert property ((ce && type_q[1] == T_GAIN_SEL)
    |=> out_q[1] == (($past(gain_set) == 2'h0) ? MV_HALF : 16'sh0000)) else $error("gain status level wrong");
  pp_sample_a: assert property ((ce && ctrl_mode == 2'h0 && !tick_q) |=> $stable(travel_zero_q))
    else $error("travel status changed between samples");
  csp_sample_a: assert property ((ce && ctrl_mode == 2'h1 && !comm_cycle_tick)
    |=> $stable(travel_zero_q)) else $error("travel status changed inside a cycle");
  ch2_range_a: assert property (out_q[1] <= MV_FULL && out_q[1] >= -MV_FULL)
    else $error("channel 2 output beyond 10 V");
  offset_floor_a: assert property ((ce && done[0] && fmt_q == FMT_OFFSET && !is_digital(type_q[0]))
    |=> out_q[0] >= 0) else $error("offset format went below 0 V");
  user_gain_a: assert property ((gain_q[1] != 32'h00000000) |-> eff_gain[1] == gain_q[1])
    else $error("nonzero gain not used as set");
  power_gain_a: assert property ((type_q[0] == T_POWER && gain_q[0] == 32'h00000000)
    |-> eff_gain[0] == G_POWER) else $error("power default gain wrong");
  turn_gain_a: assert property ((type_q[0] == T_SINGLE && gain_q[0] == 32'h00000000)
    |-> eff_gain[0] == G_SINGLE) else $error("single-turn default gain wrong");
  pre_speed_a: assert property ((type_q[1] == T_CMD_PRE) |-> sel_v[1] == cmd_vel_pre)
    else $error("pre-filter speed source wrong");
  post_speed_a: assert property ((type_q[1] == T_CMD_POST) |-> sel_v[1] == cmd_vel_post)
    else $error("post-filter speed source wrong");
  // the two position modes take the travel command only on their own sampling event; velocity and torque modes take their command every cycle
  pp_take_a: assert property ((ce && ctrl_mode == 2'h0 && tick_q)
    |=> travel_zero_q == ($past(travel_cmd) == 0)) else $error("travel status missed a sample");
  csp_take_a: assert property ((ce && ctrl_mode == 2'h1 && comm_cycle_tick)
    |=> travel_zero_q == ($past(travel_cmd) == 0)) else $error("travel status missed a cycle");
  vel_take_a: assert property ((ce && ctrl_mode == 2'h2)
    |=> travel_zero_q == ($past(vel_cmd) == 0)) else $error("velocity command status wrong");
  trq_take_a: assert property ((ce && ctrl_mode == 2'h3)
    |=> travel_zero_q == ($past(torque_cmd) == 0)) else $error("torque command status wrong");
  pos_lvl_a: assert property ((ce && type_q[0] == T_POS_DONE)
    |=> out_q[0] == ($past(pos_complete) ? MV_HALF : 16'sh0000)) else $error("positioning level wrong");
  travel_lvl_a: assert property ((ce && type_q[0] == T_TRAVEL)
    |=> out_q[0] == ($past(travel_zero_q) ? MV_HALF : 16'sh0000)) else $error("travel level wrong");
endmodule

/* File: bench/smos_meter.sv */
// partner model: monitor meter that samples both analog monitor levels
module smos_meter (
  input wire logic core_clk,
  input wire logic signed [15:0] mon1_mv,
  input wire logic signed [15:0] mon2_mv,
  output logic signed [15:0] rd1_mv,
  output logic signed [15:0] rd2_mv,
  output logic over
);
  timeunit 1ns;
  timeprecision 100ps;
  // the probe reads one edge late, so a level must stand to be seen at all
  always_ff @(posedge core_clk) begin
    rd1_mv <= mon1_mv;
    rd2_mv <= mon2_mv;
  end
  // a reading beyond full scale on either channel is flagged as a fault
  assign over = (rd1_mv > 16'sh2710) || (rd1_mv < -16'sh2710) ||
    (rd2_mv > 16'sh2710) || (rd2_mv < -16'sh2710);
endmodule

/* File: bench/servo_monitor_output_select_tb_top.sv */
// testbench: random and corner-case checks of the two monitor channels
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module servo_monitor_output_select_tb_top
  import smos_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0, pc = 1'b0, al = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat, rd_smp;
  logic [1:0] htrans = 2'h0, mode = 2'h0, gset = 2'h0;
  logic signed [31:0] v [0:31];
  wire hreadyout, hresp, over;
  wire [31:0] hrdata;
  wire signed [15:0] m1, m2, r1, r2;
  int errors = 0, n_compared = 0, cyc = 0, seed = 32'hB572;
  int t, g, mm, k, s, f, pol, dsel, slot;
  int tt [0:19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 19, 20, 21, 27};

  smos_top #(.TICK_CYC_P(8), .SEC_CYC_P(4), .WINDOW_SEC_P(3)) u_dut (.core_clk, .rst, .ce(1'b1), .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .motor_vel(v[0]), .cmd_vel_pre(v[1]), .cmd_vel_post(v[2]), .vel_loop_cmd(v[3]), .torque_cmd(v[4]),
    .pos_dev_post(v[5]), .pos_dev_pre(v[16]), .enc_dev(v[6]), .ext_dev(v[7]), .hyb_dev(v[8]), .pn_volt(v[9]),
    .regen_load(v[10]), .overload_load(v[11]), .tlim_pos(v[12]), .tlim_neg(v[13]), .speed_limit(v[14]),
    .inertia_ratio(v[15]), .enc_temp(v[19]), .drv_temp(v[20]), .enc_single_turn(v[21]), .power_w(v[27]),
    .travel_cmd(v[23]), .vel_cmd(v[24]), .ctrl_mode(mode), .comm_cycle_tick(tick), .gain_set(gset),
    .pos_complete(pc), .alarm_active(al), .mon1_mv(m1), .mon2_mv(m2));
  smos_meter u_meter (.core_clk, .mon1_mv(m1), .mon2_mv(m2), .rd1_mv(r1), .rd2_mv(r2), .over);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // read data is latched at the edge that closes the data phase
  always @(posedge core_clk) rd_smp <= hrdata;
  always @(posedge core_clk) tick <= ($random(seed) & 3) == 0;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    #1 rdat = rd_smp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic settle();
    repeat (100) @(posedge core_clk);
    #1;
  endtask
  // status types must ignore any gain, so a random one is loaded each time
  task automatic st(input int ty, input logic signed [15:0] e);
    wr(A_TYPE1, ty);
    wr(A_GAIN1, $random(seed));
    settle();
    `CHK(r1, e)
    `CHK(r2, exp_mv(s * g * mm, g * mm, 1))
  endtask
  function automatic int dg(input int ty);
    if (ty <= 3 || ty == 14) return 32'h1F4;
    if (ty == 4 || (ty >= 10 && ty <= 13)) return 32'h21;
    if (ty <= 8) return 32'hBB8;
    if (ty == 9) return 32'h50;
    if (ty == 15) return 32'h1F4;
    if (ty <= 20) return 32'hA;
    if (ty == 21) return 32'h1ADB0;
    return 32'h64;
  endfunction
  function automatic logic signed [15:0] exp_mv(input longint x, input longint gn, input int fm);
    longint m;
    longint lo;
    m = x * 1000 / gn;
    if (m > 20000) m = 20000;
    if (m < -20000) m = -20000;
    if (fm == 1 && m < 0) m = -m;
    if (fm == 2) m = m + 5000;
    lo = (fm == 0) ? -10000 : 0;
    if (m > 10000) m = 10000;
    if (m < lo) m = lo;
    return m[15:0];
  endfunction

  initial begin
    foreach (v[i]) v[i] = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a <= 8'h18; a += 4) begin
      bus(8'(a), 1'b0, 32'h0);
      `CHK(rdat, 32'h0)
    end
    bus(8'h40, 1'b0, 32'h0);
    `CHK(rdat, 32'h0)
    `CHK({hreadyout, hresp}, 2'h2)
    for (int it = 0; it < 40; it++) begin
      t = tt[it % 20]; g = dg(t); mm = 1 + $unsigned($random(seed)) % 4; k = $random(seed) % 16;
      f = $unsigned($random(seed)) % 3; pol = $random(seed) & 1; dsel = $random(seed) & 1;
      slot = (t == 5 && dsel) ? 16 : t;
      foreach (v[i]) v[i] <= (i == slot) ? k * g * mm : $random(seed) % 1000;
      wr(A_TYPE1, t); wr(A_TYPE2, t); wr(A_GAIN1, 32'h0); wr(A_GAIN2, g * mm); wr(A_FMT, f);
      wr(A_POL, pol ? 32'(POL_REVERSE) : 32'h0); wr(A_EXT2, dsel << DEV_SEL_BIT);
      settle();
      s = (pol && (t <= 8 || t == 14)) ? -k : k;
      `CHK(r1, exp_mv(s * g * mm, g, f))
      `CHK(r2, exp_mv(s * g * mm, g * mm, f))
      bus(A_OUT, 1'b0, 32'h0);
      `CHK(rdat, {exp_mv(s * g * mm, g * mm, f), exp_mv(s * g * mm, g, f)})
    end
    wr(A_FMT, 32'h1);
    pc <= 1'b1; st(25, 16'sh1388);
    pc <= 1'b0; st(25, 16'sh0);
    al <= 1'b1; st(26, 16'sh1388);
    gset <= 2'h2; st(24, 16'sh0);
    gset <= 2'h0; st(24, 16'sh1388);
    st(22, 16'sh0);
    for (int md = 0; md < 4; md++) begin
      for (int z = 0; z < 2; z++) begin
        mode <= 2'(md); v[23] <= z ? 0 : 7; v[24] <= z ? 0 : -3; v[4] <= z ? 0 : 9;
        st(23, z ? 16'sh1388 : 16'sh0);
      end
    end
    // 2400 W over a 3 s window is 2 Wh; type 27 at 100 W/V saturates
    foreach (v[i]) v[i] <= (i == 27) ? 2400 : 0;
    wr(A_FMT, 32'h0); wr(A_TYPE1, 28); wr(A_GAIN1, 32'h0); wr(A_TYPE2, 27); wr(A_GAIN2, 32'h0);
    repeat (2) settle();
    bus(A_ENERGY, 1'b0, 32'h0);
    `CHK(rdat, 32'h2)
    `CHK(r1, 16'sh14)
    `CHK(r2, 16'sh2710)
    `CHK(over, 1'b0)
    stop_test();
  end
endmodule
